// File: rtl/hold_sync.sv
/*
 Three-stage synchroniser for an asynchronous level input.
 Assumes clk is the processor clock; output changes once stages two and three agree.
*/
`timescale 1ns/10ps
module hold_sync (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic din,
    output logic dout
);
    logic s1;
    logic s2;
    logic s3;
    wire agree = (s2 == s3);

    // Shift chain and agreement filter
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            dout <= 1'b0;
        end else if (ce) begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (agree) begin
                dout <= s3;
            end
        end
    end
endmodule

// File: rtl/local_bus_pins.sv
/*
 Local bus pin logic: status encoding, hold handshake, chip selects,
 transceiver direction and enable, with output enables for floating pins.
 Assumes a bus-cycle sequencer on the same clock supplies cycle type,
 T-state boundaries and the address; range limits come from config logic.
*/
// Summary of operation
// - Status pins encode cycle type: INTA, IO rd/wr, halt, fetch, mem rd/wr, passive.
// - Status pins float while the bus is held by another master.
// - Top status bit marks memory vs I/O; middle bit follows transfer direction.
// - Hold request is asynchronous and is synchronised before use.
// - Hold acknowledge rises only at the end of final or idle state.
// - Bus and control lines float in the same cycle acknowledge rises.
// - Once request seen low, acknowledge drops and lines are driven again.
// - Upper select low for memory references in the top block.
// - Lower select low for memory references in the bottom block.
// - Four mid selects low for references in the mid-range area.
// - Five peripheral selects low for references in the I/O peripheral area.
// - Memory and peripheral selects stay driven during hold.
// - Two shared pins give peripheral selects 5/6 or latched address bits 1/2.
// - In latched-address use the shared pins keep their value during hold.
// - Direction low for reads toward processor, high for writes.
// - Enable low during accesses and high whenever direction changes.
// - Enable high one clock in reset then floats; floats during hold.
// - Status pins show passive during reset, then float.
`timescale 1ns/10ps
`include "bus_pins_defines.svh"
module local_bus_pins #(
    parameter int NMID = `MID_SEL_COUNT,
    parameter int NPER = `PERIPH_SEL_COUNT
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic busReset,
    input wire logic [2:0] cycleType,
    input wire logic cycleStart,
    input wire logic dataPhase,
    input wire logic finalState,
    input wire logic idleState,
    input wire logic [19:0] addr,
    input wire logic holdReq,
    input wire logic addrMode1,
    input wire logic addrMode2,
    input wire logic [19:0] upperBase,
    input wire logic [19:0] lowerTop,
    input wire logic [19:0] midBase,
    input wire logic [19:0] midBlock,
    input wire logic [15:0] periphBase,
    output logic [2:0] busCycleStatus,
    output logic busCycleStatusOe,
    output logic holdAck,
    output logic busOe,
    output logic upperMemSelect_n,
    output logic lowerMemSelect_n,
    output logic [NMID-1:0] midMemSelect_n,
    output logic [NPER-1:0] periphSelect_n,
    output logic periphSelect5OrAddr1,
    output logic periphSelect6OrAddr2,
    output logic xcvrDirection,
    output logic xcvrDirectionOe,
    output logic xcvrEnable,
    output logic xcvrEnableOe
);
    // Elaboration check: the decode serves four mid and five peripheral selects only
    if (NMID != 4 || NPER != 5) begin : g_bad_params
        $error("local_bus_pins supports four mid and five peripheral selects only");
    end

    bus_pins_pkg::arb_e arb;
    bus_pins_pkg::arb_e next_arb;
    logic holdSeen;
    logic [2:0] curType;
    logic inCycle;
    logic dirHold;
    logic resetDone;
    logic upperHit;
    logic lowerHit;
    logic [NMID-1:0] midHit;
    logic [NPER+1:0] periphHit;

    // Synchronised hold request
    hold_sync u_sync (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .din(holdReq),
        .dout(holdSeen)
    );

    // Address range decode for the selects
    select_decode #(
        .NMID(NMID),
        .NPER(NPER + 2)
    ) u_dec (
        .addr(addr),
        .isMem(inCycle && curType[`STAT_MIO_BIT] && curType != `STAT_PASSIVE),
        .isIo(inCycle && (curType == `STAT_IORD || curType == `STAT_IOWR)),
        .upperBase(upperBase),
        .lowerTop(lowerTop),
        .midBase(midBase),
        .midBlock(midBlock),
        .periphBase(periphBase),
        .upperHit(upperHit),
        .lowerHit(lowerHit),
        .midHit(midHit),
        .periphHit(periphHit)
    );

    // Grant decisions at bus state boundaries only
    wire atBoundary = finalState || idleState;
    wire grant = (arb == bus_pins_pkg::ARB_OWN) && holdSeen && atBoundary && !busReset;
    wire release_ = (arb == bus_pins_pkg::ARB_HELD) && !holdSeen;
    wire held = (arb == bus_pins_pkg::ARB_HELD);

    // Cycle status and direction decode
    wire [2:0] nextType = cycleStart ? cycleType : (finalState ? `STAT_PASSIVE : curType);
    wire isWrite = (nextType == `STAT_IOWR) || (nextType == `STAT_MEMWR);
    wire nextDir = nextType[`STAT_DIR_BIT];
    wire dirChange = (nextDir != dirHold);
    wire access = inCycle && dataPhase && (curType != `STAT_HALT);
    wire nextEnable = !access || dirChange;

    // Arbitration state
    always_comb begin
        next_arb = arb;
        case (arb)
            bus_pins_pkg::ARB_OWN: begin
                if (grant) begin
                    next_arb = bus_pins_pkg::ARB_HELD;
                end
            end
            bus_pins_pkg::ARB_HELD: begin
                if (release_) begin
                    next_arb = bus_pins_pkg::ARB_OWN;
                end
            end
            default: next_arb = bus_pins_pkg::ARB_OWN;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            arb <= bus_pins_pkg::ARB_OWN;
        end else if (ce) begin
            arb <= busReset ? bus_pins_pkg::ARB_OWN : next_arb;
        end
    end

    // Cycle tracking
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            curType <= `STAT_PASSIVE;
            inCycle <= 1'b0;
        end else if (ce) begin
            curType <= (busReset || held) ? `STAT_PASSIVE : nextType;
            inCycle <= !busReset && !held && (cycleStart || (inCycle && !finalState));
        end
    end

    // Reset marker: limits driven-high enable and status to one clock of reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            resetDone <= 1'b0;
        end else if (ce) begin
            resetDone <= busReset ? 1'b1 : 1'b0;
        end
    end

    // Handshake and float controls
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            holdAck <= 1'b0;
            busOe <= 1'b0;
        end else if (ce) begin
            holdAck <= !busReset && (next_arb == bus_pins_pkg::ARB_HELD);
            busOe <= !busReset && (next_arb == bus_pins_pkg::ARB_OWN);
        end
    end

    // Status pins: passive in reset, float in hold
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busCycleStatus <= `STAT_PASSIVE;
            busCycleStatusOe <= 1'b1;
        end else if (ce) begin
            busCycleStatus <= (busReset || grant || held) ? `STAT_PASSIVE : nextType;
            busCycleStatusOe <= (busReset && !resetDone)
                || (!busReset && next_arb == bus_pins_pkg::ARB_OWN);
        end
    end

    // Transceiver direction and enable
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dirHold <= 1'b0;
            xcvrDirection <= 1'b0;
            xcvrDirectionOe <= 1'b0;
            xcvrEnable <= 1'b1;
            xcvrEnableOe <= 1'b1;
        end else if (ce) begin
            dirHold <= (cycleStart && !held) ? isWrite : dirHold;
            xcvrDirection <= (cycleStart && !held) ? isWrite : dirHold;
            xcvrDirectionOe <= !busReset && (next_arb == bus_pins_pkg::ARB_OWN);
            xcvrEnable <= busReset ? 1'b1 : nextEnable;
            xcvrEnableOe <= (busReset && !resetDone)
                || (!busReset && next_arb == bus_pins_pkg::ARB_OWN);
        end
    end

    // Chip selects, always driven, active low
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            upperMemSelect_n <= 1'b1;
            lowerMemSelect_n <= 1'b1;
            midMemSelect_n <= '1;
            periphSelect_n <= '1;
        end else if (ce) begin
            upperMemSelect_n <= !upperHit;
            lowerMemSelect_n <= !lowerHit;
            midMemSelect_n <= ~midHit;
            periphSelect_n <= ~periphHit[NPER-1:0];
        end
    end

    // Shared pins: select 5/6 or latched address, address frozen in hold
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            periphSelect5OrAddr1 <= 1'b1;
            periphSelect6OrAddr2 <= 1'b1;
        end else if (ce) begin
            if (!addrMode1) begin
                periphSelect5OrAddr1 <= !periphHit[NPER];
            end else if (cycleStart && !held) begin
                periphSelect5OrAddr1 <= addr[1];
            end
            if (!addrMode2) begin
                periphSelect6OrAddr2 <= !periphHit[NPER+1];
            end else if (cycleStart && !held) begin
                periphSelect6OrAddr2 <= addr[2];
            end
        end
    end
endmodule

// File: rtl/select_decode.sv
/*
 Chip-select range decoder: compares a 20-bit address against programmed blocks.
 Assumes range limits arrive from the chip-select configuration logic outside.
*/
`timescale 1ns/10ps
module select_decode #(
    parameter int NMID = 4,
    parameter int NPER = 7
) (
    input wire logic [19:0] addr,
    input wire logic isMem,
    input wire logic isIo,
    input wire logic [19:0] upperBase,
    input wire logic [19:0] lowerTop,
    input wire logic [19:0] midBase,
    input wire logic [19:0] midBlock,
    input wire logic [15:0] periphBase,
    output logic upperHit,
    output logic lowerHit,
    output logic [NMID-1:0] midHit,
    output logic [NPER-1:0] periphHit
);
    wire [19:0] midOff = addr - midBase;
    wire [15:0] perOff = addr[15:0] - periphBase;
    wire midIn = isMem && (addr >= midBase);
    wire perIn = isIo && (addr[19:16] == 4'h0) && (addr[15:0] >= periphBase);

    // Upper and lower blocks
    assign upperHit = isMem && (addr >= upperBase);
    assign lowerHit = isMem && (addr <= lowerTop);

    // Mid-range area split into equal blocks
    genvar i;
    generate
        for (i = 0; i < NMID; i++) begin : g_mid
            assign midHit[i] = midIn && (midOff < midBlock * 20'(i + 1))
                && (midOff >= midBlock * 20'(i));
        end
        // Peripheral area split into 128-byte blocks
        for (i = 0; i < NPER; i++) begin : g_per
            assign periphHit[i] = perIn && (perOff[15:7] == 9'(i));
        end
    endgenerate
endmodule

// File: shared/bus_pins_defines.svh
/*
 Constants for the local bus pin block: status codes, reset values, widths.
 Assumes inclusion by bare name from the design files.
*/
`ifndef BUS_PINS_DEFINES_SVH
`define BUS_PINS_DEFINES_SVH
`define STAT_INTA 3'h0
`define STAT_IORD 3'h1
`define STAT_IOWR 3'h2
`define STAT_HALT 3'h3
`define STAT_FETCH 3'h4
`define STAT_MEMRD 3'h5
`define STAT_MEMWR 3'h6
`define STAT_PASSIVE 3'h7
`define STAT_MIO_BIT 2
`define STAT_DIR_BIT 1
`define MID_SEL_COUNT 4
`define PERIPH_SEL_COUNT 5
`define XEN_RESET_CLOCKS 1
`endif

// File: shared/bus_pins_pkg.sv
/*
 Types for the local bus pin block.
 Assumes the defines header is compiled alongside.
*/
package bus_pins_pkg;
    typedef enum logic [2:0] {
        CYC_INTA, CYC_IORD, CYC_IOWR, CYC_HALT, CYC_FETCH, CYC_MEMRD, CYC_MEMWR, CYC_PASSIVE
    } cycle_e;
    typedef enum logic [1:0] {ARB_OWN, ARB_HELD} arb_e;
endpackage

// File: verif/bus_pins_checker.sv
/* Concurrent checks on the local bus pin block.
 Assumes one clk domain, nrst asynchronous active low, bound by the statement at the foot. */
`timescale 1ns/10ps
`include "bus_pins_defines.svh"
module bus_pins_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic busReset,
    input wire logic [2:0] cycleType,
    input wire logic cycleStart,
    input wire logic finalState,
    input wire logic idleState,
    input wire logic holdReq,
    input wire logic [2:0] busCycleStatus,
    input wire logic busCycleStatusOe,
    input wire logic holdAck,
    input wire logic busOe,
    input wire logic xcvrDirection,
    input wire logic xcvrDirectionOe,
    input wire logic xcvrEnable,
    input wire logic xcvrEnableOe
);
    // Common clock and reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Handshake, floating and encoding relations
    property p_float; holdAck |-> !busOe && !busCycleStatusOe && !xcvrEnableOe; endproperty
    a_float: assert property (p_float) else $error("lines driven in hold");
    property p_bound; $rose(holdAck) |-> $past(finalState) || $past(idleState); endproperty
    a_bound: assert property (p_bound) else $error("grant mid cycle");
    property p_sync; $rose(holdAck) |-> $past(holdReq, 3); endproperty
    a_sync: assert property (p_sync) else $error("grant too early");
    property p_drop; holdAck && !holdReq |-> ##[1:6] !holdAck; endproperty
    a_drop: assert property (p_drop) else $error("grant kept");
    property p_keep; $fell(holdAck) |-> !$past(holdReq, 2); endproperty
    a_keep: assert property (p_keep) else $error("grant lost");
    property p_rstfl; $rose(busReset) ##3 busReset |-> !xcvrEnableOe && !busCycleStatusOe; endproperty
    a_rstfl: assert property (p_rstfl) else $error("reset float late");
    property p_rstpas; busReset && busCycleStatusOe |-> busCycleStatus == `STAT_PASSIVE; endproperty
    a_rstpas: assert property (p_rstpas) else $error("reset status");
    property p_code; cycleStart && !busReset && !holdAck |=> busCycleStatus == $past(cycleType); endproperty
    a_code: assert property (p_code) else $error("status code");
    property p_den; $changed(xcvrDirection) && xcvrDirectionOe |-> xcvrEnable; endproperty
    a_den: assert property (p_den) else $error("enable low at turn");
endmodule
bind local_bus_pins bus_pins_checker u_chk (.*);

// File: verif/hold_master.sv
/* Behavioural external master asking for the local bus.
 Assumes the bench raises want while the master needs the bus. */
`timescale 1ns/10ps
module hold_master (
    input wire logic want,
    output logic holdReq
);
    // Request off the processor clock grid, kept while wanted
    initial holdReq = 1'b0;
    always @(want) begin
        #7 holdReq = want;
    end
endmodule

// File: verif/local_bus_status_hold_chipselect_bench.sv
/* Self-checking bench for local_bus_pins with a behavioural hold master.
 Assumes the checker binds itself; inputs change 1 ns after rising edges. */
`timescale 1ns/10ps
`include "bus_pins_defines.svh"
module local_bus_status_hold_chipselect_bench;
    logic clk, nrst, ce, busReset, cycleStart, dataPhase, finalState, idleState;
    logic [2:0] cycleType;
    logic [19:0] addr, upperBase, lowerTop, midBase, midBlock;
    logic [15:0] periphBase;
    logic holdReq, want, addrMode1, addrMode2, holdAck, busOe;
    logic [2:0] busCycleStatus;
    logic busCycleStatusOe, upperMemSelect_n, lowerMemSelect_n;
    logic [3:0] midMemSelect_n;
    logic [4:0] periphSelect_n;
    logic periphSelect5OrAddr1, periphSelect6OrAddr2;
    logic xcvrDirection, xcvrDirectionOe, xcvrEnable, xcvrEnableOe;
    logic [26:0] rows [15];
    int errors, nChecks, cycles, i;
    // Design and far-side master
    local_bus_pins u_dut (.*);
    hold_master u_master (.want, .holdReq);
    // Clock at 25 ns
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Cycle ceiling against a hang
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            errors++;
            close_out();
        end
    end
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Selects packed: upper, lower, mid 0-3, periph 0-4, shared 5 and 6
    function automatic logic [12:0] sel;
        sel = {periphSelect6OrAddr2, periphSelect5OrAddr1, periphSelect_n, midMemSelect_n,
            lowerMemSelect_n, upperMemSelect_n};
    endfunction
    // Start, two data states
    task automatic runCycle(input logic [2:0] t, input logic [19:0] a);
        cycleType = t;
        addr = a;
        cycleStart = 1'b1;
        idleState = 1'b0;
        tick();
        cycleStart = 1'b0;
        dataPhase = 1'b1;
        tick();
        tick();
    endtask
    // Final state, two idle states
    task automatic endCycle;
        dataPhase = 1'b0;
        finalState = 1'b1;
        tick();
        finalState = 1'b0;
        idleState = 1'b1;
        tick();
        tick();
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", nChecks, errors);
        if (errors == 0 && nChecks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        {nrst, ce, cycleStart, dataPhase, finalState, idleState, want} = 7'h22;
        {busReset, addrMode1, addrMode2, cycleType, addr} = {1'b1, 25'h000_0000};
        upperBase = 20'hF_C000;
        lowerTop = 20'h0_3FFF;
        midBase = 20'h8_0000;
        midBlock = 20'h0_2000;
        periphBase = 16'h0400;
        // Type, address, hit index: 0 none, 1 upper, 2 lower, 3-6 mid, 7-13 periph
        rows = '{{3'h5, 20'hF_C010, 4'h1}, {3'h6, 20'h0_0100, 4'h2}, {3'h5, 20'h0_0400, 4'h2},
            {3'h4, 20'h8_0000, 4'h3}, {3'h5, 20'h8_2000, 4'h4}, {3'h6, 20'h8_7FFE, 4'h6},
            {3'h5, 20'h4_0000, 4'h0}, {3'h1, 20'h0_0400, 4'h7}, {3'h2, 20'h0_047F, 4'h7},
            {3'h1, 20'h0_0600, 4'hB}, {3'h2, 20'h0_0680, 4'hC}, {3'h1, 20'h0_0700, 4'hD},
            {3'h1, 20'h1_0400, 4'h0}, {3'h0, 20'h0_0000, 4'h0}, {3'h3, 20'h0_0000, 4'h0}};
        repeat (6) tick();
        chk({busCycleStatus, busCycleStatusOe, holdAck, busOe, xcvrEnable, xcvrEnableOe,
            xcvrDirectionOe}, 9'h1E6);
        chk(sel(), 13'h1FFF);
        nrst = 1'b1;
        repeat (3) tick();
        chk({busCycleStatusOe, xcvrEnableOe}, 2'h0);
        busReset = 1'b0;
        repeat (2) tick();
        $display("reset test done");
        for (i = 0; i < 15; i++) begin
            runCycle(rows[i][26:24], rows[i][23:4]);
            chk(busCycleStatus, rows[i][26:24]);
            chk(sel(), 13'(rows[i][3:0] == 0 ? 13'h1FFF : ~(13'h1 << (rows[i][3:0] - 1))));
            if (rows[i][26:24] != `STAT_HALT) begin
                chk({xcvrDirection, xcvrEnable}, {rows[i][25], 1'b0});
            end
            endCycle();
        end
        $display("row test done");
        ce = 1'b0;
        repeat (3) tick();
        ce = 1'b1;
        {addrMode1, addrMode2} = 2'h3;
        runCycle(`STAT_IORD, 20'h0_0004);
        want = 1'b1;
        repeat (8) tick();
        chk(holdAck, 1'b0);
        chk({periphSelect6OrAddr2, periphSelect5OrAddr1}, 2'h2);
        endCycle();
        chk({holdAck, busOe, busCycleStatusOe, xcvrEnableOe, xcvrDirectionOe}, 5'h10);
        chk(sel(), 13'h17FF);
        want = 1'b0;
        for (i = 0; i < 10 && holdAck !== 1'b0; i++) tick();
        chk({holdAck, busOe, busCycleStatusOe}, 3'h3);
        $display("hold test done");
        busReset = 1'b1;
        repeat (4) tick();
        chk({busCycleStatusOe, xcvrEnableOe, busOe}, 3'h0);
        busReset = 1'b0;
        repeat (2) tick();
        $display("bus reset test done");
        close_out();
    end
endmodule
